// ### usb_cfg_pkg.sv
// Settings, offsets, fields and timing of the host configuration core.
// Assumes a 32-bit register port and an 8-bit PHY link.
package usb_cfg_pkg;
  // Default build settings
  localparam int unsigned DEF_FULL_SPEED = 1;
  localparam int unsigned DEF_PWR_PRESENT = 1;
  localparam int unsigned DEF_CHARGE_PUMP = 0;
  localparam int unsigned DEF_EXT_MONITOR = 1;
  localparam int unsigned DEF_EXT_INVERT = 0;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DEF_DATA_W = 32;
  localparam int unsigned DEF_MASTER_COUNT = 1;
  localparam int unsigned DEF_MID_W = 1;
  localparam int unsigned DEF_P2P = 0;
  localparam int unsigned DEF_PERIOD_PS = 10000;
  localparam logic [31:0] DEF_WINDOW_BASE = 32'hFFFF_FFFF;
  localparam logic [31:0] DEF_WINDOW_HIGH = 32'h0000_0000;
  // Offsets in the 200 hex byte window
  localparam logic [8:0] OFF_CONFIG = 9'h010;
  localparam logic [8:0] OFF_PHY_CTRL = 9'h014;
  localparam logic [8:0] OFF_DMA_ADDR = 9'h018;
  localparam logic [8:0] OFF_DMA_DATA = 9'h01C;
  localparam logic [8:0] OFF_DMA_CMD = 9'h020;
  localparam logic [8:0] OFF_DMA_RDATA = 9'h024;
  localparam logic [8:0] OFF_CAPLEN = 9'h100;
  localparam logic [8:0] OFF_STRUCT = 9'h104;
  localparam logic [31:0] CAPLEN_VAL = 32'h0100_0040;
  localparam logic [3:0] NUM_PORTS = 4'h1;
  localparam int unsigned PPC_BIT = 4;
  // Config status bits
  localparam int unsigned CFG_FS_BIT = 0;
  localparam int unsigned CFG_PWR_BIT = 1;
  localparam int unsigned CFG_PUMP_BIT = 2;
  localparam int unsigned CFG_EXT_BIT = 3;
  localparam int unsigned CFG_INV_BIT = 4;
  localparam int unsigned CFG_P2P_BIT = 5;
  localparam int unsigned CFG_DONE_BIT = 8;
  localparam int unsigned CFG_DMA_BUSY_BIT = 9;
  localparam int unsigned CFG_PROG_BUSY_BIT = 10;
  localparam int unsigned PHY_PWR_BIT = 0;
  localparam int unsigned CMD_GO_BIT = 0;
  localparam int unsigned CMD_RNW_BIT = 1;
  localparam logic PHY_PWR_RESET = 1'b0;
  // PHY registers written at setup
  localparam logic [1:0] PHY_REG_WRITE = 2'h2;
  localparam logic [5:0] PHY_OTG_CTRL = 6'h0A;
  localparam logic [5:0] PHY_IFC_CTRL = 6'h07;
  localparam int unsigned OTG_DRV_VBUS_BIT = 5;
  localparam int unsigned OTG_DRV_EXT_BIT = 6;
  localparam int unsigned OTG_EXT_IND_BIT = 7;
  localparam int unsigned IFC_IND_INV_BIT = 5;
  // PHY reset hold time
  localparam int unsigned PHY_SETTLE_NS = 2000;
  localparam int unsigned PS_PER_NS = 1000;
endpackage

// ### ulpi_prog_if.sv
// Register-write request from the system domain to the link domain.
// Assumes data stand still from request toggle until ack toggle.
`timescale 1ns/1ns
interface ulpi_prog_if;
  logic req_tgl;
  logic [5:0] addr;
  logic [7:0] data;
  logic ack_tgl;
  modport sys (output req_tgl, output addr, output data, input ack_tgl);
  modport link (input req_tgl, input addr, input data, output ack_tgl);
endinterface

// ### ulpi_reg_writer.sv
// PHY register writer running on the PHY link clock.
// Assumes dir and nxt are synchronous to the link clock.
`timescale 1ns/1ns
module ulpi_reg_writer
  import usb_cfg_pkg::*;
(
  // Clock and reset
  input wire logic link_clk_i,
  input wire logic sys_rst_i,
  // Request from system domain
  ulpi_prog_if.link prog,
  // PHY pins
  input wire logic ulpi_dir_i,
  input wire logic ulpi_nxt_i,
  output logic [7:0] ulpi_data_o,
  output logic ulpi_data_oe_o,
  output logic ulpi_stp_o
);
  typedef enum {L_IDLE, L_CMD, L_DATA, L_STP} link_st_e;
  link_st_e st_ff;
  logic [1:0] rst_sync_ff;
  logic link_rst;
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_seen_ff;
  logic ack_ff;
  logic pending;

  // Reset leaves on the link clock so the machine starts cleanly
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_sync_ff <= 2'b11;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b0};
    end
  end
  assign link_rst = rst_sync_ff[1];

  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end else begin
      req_s1_ff <= prog.req_tgl;
      req_s2_ff <= req_s1_ff;
    end
  end
  assign pending = req_s2_ff != req_seen_ff;
  assign prog.ack_tgl = ack_ff;

  // PHY owns the bus while dir is high; an interrupted write is retried
  always_ff @(posedge link_clk_i or posedge link_rst) begin
    if (link_rst) begin
      st_ff <= L_IDLE;
      ulpi_data_o <= 8'h00;
      ulpi_data_oe_o <= 1'b0;
      ulpi_stp_o <= 1'b0;
      req_seen_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      case (st_ff)
        L_IDLE: begin
          ulpi_stp_o <= 1'b0;
          if (pending && !ulpi_dir_i) begin
            ulpi_data_o <= {PHY_REG_WRITE, prog.addr};
            ulpi_data_oe_o <= 1'b1;
            st_ff <= L_CMD;
          end else begin
            ulpi_data_o <= 8'h00;
            ulpi_data_oe_o <= 1'b0;
          end
        end
        L_CMD, L_DATA: begin
          if (ulpi_dir_i) begin
            ulpi_data_o <= 8'h00;
            ulpi_data_oe_o <= 1'b0;
            st_ff <= L_IDLE;
          end else if (ulpi_nxt_i && st_ff == L_CMD) begin
            ulpi_data_o <= prog.data;
            st_ff <= L_DATA;
          end else if (ulpi_nxt_i) begin
            ulpi_data_o <= 8'h00;
            ulpi_stp_o <= 1'b1;
            st_ff <= L_STP;
          end
        end
        L_STP: begin
          ulpi_stp_o <= 1'b0;
          ulpi_data_oe_o <= 1'b0;
          req_seen_ff <= req_s2_ff;
          ack_ff <= ~ack_ff;
          st_ff <= L_IDLE;
        end
        default: st_ff <= L_IDLE;
      endcase
    end
  end
endmodule

// ### usb_host_cfg_core.sv
// Build-time configuration core of a USB 2.0 host.
// Assumes a one-cycle register port and a PHY-driven link clock.
// Behaviour
// - Capability bit reflects power control presence
// - No power control: ignore pump and monitor
// - No external monitor: ignore inversion setting
// - Charge pump used: ignore monitor settings
// - Point-to-point: ignore window base, high
// - Full speed setting enables split transfers
// - Master identifier width from setting
// - Busy and error buses per master
// - DMA data buses sized by master width
// - Slave data buses sized by slave width
// - Timer counts derived from clock period
// - Invert setting programs PHY indicator inversion
// - External monitor programs PHY indicator source
// - Charge pump setting programs PHY VBUS drive
// - Decode 200 hex byte window at base
// - Address buses are 32 bits wide
// - Point-to-point answers every access
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module usb_host_cfg_core
  import usb_cfg_pkg::*;
#(
  parameter int unsigned full_speed_support_enable = DEF_FULL_SPEED,
  parameter int unsigned port_power_control_present = DEF_PWR_PRESENT,
  parameter int unsigned phy_charge_pump_vbus = DEF_CHARGE_PUMP,
  parameter int unsigned external_vbus_monitor_select = DEF_EXT_MONITOR,
  parameter int unsigned external_vbus_monitor_invert = DEF_EXT_INVERT,
  parameter int unsigned master_address_width = ADDR_W,
  parameter int unsigned master_data_width = DEF_DATA_W,
  parameter int unsigned master_point_to_point = DEF_P2P,
  parameter logic [31:0] register_window_base = DEF_WINDOW_BASE,
  parameter logic [31:0] register_window_high = DEF_WINDOW_HIGH,
  parameter int unsigned master_id_width = DEF_MID_W,
  parameter int unsigned bus_master_count = DEF_MASTER_COUNT,
  parameter int unsigned slave_address_width = ADDR_W,
  parameter int unsigned slave_data_width = DEF_DATA_W,
  parameter int unsigned slave_point_to_point = DEF_P2P,
  parameter int unsigned system_clock_period_ps = DEF_PERIOD_PS
)
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [slave_address_width-1:0] reg_addr_i,
  input wire logic [slave_data_width/8-1:0] reg_be_i,
  input wire logic [slave_data_width-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [master_id_width-1:0] requesting_master_identifier_i,
  output logic [slave_data_width-1:0] reg_rdata_o,
  output logic [bus_master_count-1:0] slave_busy_reply_bus_o,
  output logic [bus_master_count-1:0] slave_error_reply_bus_o,
  // DMA master port
  output logic m_req_o,
  output logic m_rnw_o,
  output logic [master_address_width-1:0] m_addr_o,
  output logic [master_data_width/8-1:0] m_be_o,
  output logic [master_data_width-1:0] m_wr_data_o,
  input wire logic [master_data_width-1:0] m_rd_data_i,
  input wire logic m_addr_ack_i,
  input wire logic m_wr_ack_i,
  input wire logic m_rd_ack_i,
  // Build status
  output logic split_transfer_enable_o,
  output logic phy_reset_o,
  // PHY link
  input wire logic phy_link_clock_i,
  input wire logic ulpi_dir_i,
  input wire logic ulpi_nxt_i,
  output logic [7:0] ulpi_data_o,
  output logic ulpi_data_oe_o,
  output logic ulpi_stp_o
);
  // Effective settings; a disregarded one folds to zero here only
  localparam bit PWR = port_power_control_present != 0;
  localparam bit PUMP = PWR && phy_charge_pump_vbus != 0;
  localparam bit EXT_MON = PWR && !PUMP && external_vbus_monitor_select != 0;
  localparam bit EXT_INV = EXT_MON && external_vbus_monitor_invert != 0;
  localparam bit P2P = slave_point_to_point != 0;
  localparam bit FS = full_speed_support_enable != 0;
  localparam int unsigned SETTLE_RAW =
    (PHY_SETTLE_NS * PS_PER_NS + system_clock_period_ps - 1) / system_clock_period_ps;
  localparam int unsigned SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int unsigned MBE_W = master_data_width / 8;

  typedef enum {S_SETTLE, S_IDLE, S_OTG, S_OTG_WAIT, S_IFC, S_IFC_WAIT} prog_st_e;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  ulpi_prog_if prog_if ();

  prog_st_e st_ff;
  logic [15:0] settle_cnt_ff;
  logic port_power_ff;
  logic reprog_ff;
  logic done_ff;
  logic req_tgl_ff;
  logic [5:0] prog_addr_ff;
  logic [7:0] prog_data_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_seen_ff;
  logic ack_evt;
  logic [31:0] dma_addr_ff;
  logic [31:0] dma_data_ff;
  logic [31:0] dma_rdata_ff;
  logic dma_busy_ff;
  logic [31:0] rel_addr;
  logic [8:0] offset;
  logic hit;
  logic mapped;
  logic wr_ok;
  logic acc_hit;
  logic [31:0] rd_word;
  logic [31:0] cfg_word;
  logic [31:0] struct_word;
  logic [7:0] otg_val;
  logic drv_on;
  logic dma_go;
  logic reprog_set;

  // Window decode: base to high, or everything in point-to-point mode
  assign rel_addr = reg_addr_i - register_window_base;
  assign hit = P2P ? 1'b1 :
    (reg_addr_i >= register_window_base && reg_addr_i <= register_window_high);
  assign offset = P2P ? reg_addr_i[8:0] : rel_addr[8:0];
  assign acc_hit = (reg_we_i || reg_re_i) && hit;
  assign wr_ok = reg_we_i && hit && mapped;

  always_comb begin
    struct_word = 32'h0000_0000;
    struct_word[3:0] = NUM_PORTS;
    struct_word[PPC_BIT] = PWR;
    cfg_word = 32'h0000_0000;
    cfg_word[CFG_FS_BIT] = FS;
    cfg_word[CFG_PWR_BIT] = PWR;
    cfg_word[CFG_PUMP_BIT] = PUMP;
    cfg_word[CFG_EXT_BIT] = EXT_MON;
    cfg_word[CFG_INV_BIT] = EXT_INV;
    cfg_word[CFG_P2P_BIT] = P2P;
    cfg_word[CFG_DONE_BIT] = done_ff;
    cfg_word[CFG_DMA_BUSY_BIT] = dma_busy_ff;
    cfg_word[CFG_PROG_BUSY_BIT] = st_ff != S_IDLE;
  end

  // Unmapped offsets answer with an error
  always_comb begin
    mapped = P2P || rel_addr[31:9] == 23'h000000;
    rd_word = 32'h0000_0000;
    case (offset)
      OFF_CONFIG: rd_word = cfg_word;
      OFF_PHY_CTRL: rd_word = {31'h00000000, port_power_ff};
      OFF_DMA_ADDR: rd_word = dma_addr_ff;
      OFF_DMA_DATA: rd_word = dma_data_ff;
      OFF_DMA_CMD: rd_word = 32'h0000_0000;
      OFF_DMA_RDATA: rd_word = dma_rdata_ff;
      OFF_CAPLEN: rd_word = CAPLEN_VAL;
      OFF_STRUCT: rd_word = struct_word;
      default: mapped = 1'b0;
    endcase
  end

  // Registers live in the low lane; upper lanes read as zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i && hit && mapped) begin
      reg_rdata_o <= slave_data_width'(rd_word);
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // One reply bit per master
  for (genvar m = 0; m < bus_master_count; m++) begin : g_reply
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        slave_busy_reply_bus_o[m] <= 1'b0;
        slave_error_reply_bus_o[m] <= 1'b0;
      end else begin
        slave_busy_reply_bus_o[m] <= acc_hit && int'(requesting_master_identifier_i) == m;
        slave_error_reply_bus_o[m] <= acc_hit && !mapped &&
          int'(requesting_master_identifier_i) == m;
      end
    end
  end

  // Port power only steers the PHY when power control exists
  assign reprog_set = PWR && wr_ok && offset == OFF_PHY_CTRL && reg_be_i[0];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_power_ff <= PHY_PWR_RESET;
    end else if (wr_ok && offset == OFF_PHY_CTRL && reg_be_i[0]) begin
      port_power_ff <= reg_wdata_i[PHY_PWR_BIT];
    end
  end

  // DMA staging registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dma_addr_ff <= 32'h0000_0000;
      dma_data_ff <= 32'h0000_0000;
    end else if (wr_ok && offset == OFF_DMA_ADDR) begin
      dma_addr_ff <= merge_bytes(dma_addr_ff, reg_wdata_i[31:0], reg_be_i[3:0]);
    end else if (wr_ok && offset == OFF_DMA_DATA) begin
      dma_data_ff <= merge_bytes(dma_data_ff, reg_wdata_i[31:0], reg_be_i[3:0]);
    end
  end

  // A start while busy is dropped; software polls the busy bit
  assign dma_go = wr_ok && offset == OFF_DMA_CMD && reg_be_i[0] && reg_wdata_i[CMD_GO_BIT]
    && !dma_busy_ff;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_req_o <= 1'b0;
      m_rnw_o <= 1'b0;
      m_addr_o <= '0;
      m_be_o <= '0;
      m_wr_data_o <= '0;
      dma_busy_ff <= 1'b0;
    end else if (dma_go) begin
      m_req_o <= 1'b1;
      m_rnw_o <= reg_wdata_i[CMD_RNW_BIT];
      m_addr_o <= master_address_width'(dma_addr_ff);
      m_be_o <= MBE_W'(4'hF);
      m_wr_data_o <= {(master_data_width / 32){dma_data_ff}};
      dma_busy_ff <= 1'b1;
    end else begin
      if (m_addr_ack_i) begin
        m_req_o <= 1'b0;
      end
      if (m_rd_ack_i || m_wr_ack_i) begin
        dma_busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dma_rdata_ff <= 32'h0000_0000;
    end else if (m_rd_ack_i && dma_busy_ff) begin
      dma_rdata_ff <= m_rd_data_i[31:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      split_transfer_enable_o <= 1'b0;
    end else begin
      split_transfer_enable_o <= FS;
    end
  end

  // Acknowledge toggle from the link domain
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else begin
      ack_s1_ff <= prog_if.ack_tgl;
      ack_s2_ff <= ack_s1_ff;
      ack_seen_ff <= ack_s2_ff;
    end
  end
  assign ack_evt = ack_s2_ff != ack_seen_ff;

  // PHY values follow only the settings in force
  assign drv_on = PWR ? port_power_ff : 1'b0;
  always_comb begin
    otg_val = 8'h00;
    otg_val[OTG_DRV_VBUS_BIT] = PUMP && drv_on;
    otg_val[OTG_DRV_EXT_BIT] = PWR && !PUMP && drv_on;
    otg_val[OTG_EXT_IND_BIT] = EXT_MON;
  end

  // Reprogram request: a write beside the clear wins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reprog_ff <= 1'b1;
    end else begin
      reprog_ff <= reprog_set || (reprog_ff && st_ff != S_IDLE) ||
        (reprog_ff && st_ff == S_IDLE && settle_cnt_ff != 16'h0000);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= S_SETTLE;
      settle_cnt_ff <= 16'h0000;
      phy_reset_o <= 1'b1;
      done_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      prog_addr_ff <= 6'h00;
      prog_data_ff <= 8'h00;
    end else begin
      case (st_ff)
        S_SETTLE: begin
          if (settle_cnt_ff == 16'(SETTLE_CYC - 1)) begin
            settle_cnt_ff <= 16'h0000;
            phy_reset_o <= 1'b0;
            st_ff <= S_IDLE;
          end else begin
            settle_cnt_ff <= settle_cnt_ff + 16'h0001;
          end
        end
        S_IDLE: begin
          if (reprog_ff) begin
            st_ff <= S_OTG;
          end
        end
        S_OTG: begin
          prog_addr_ff <= PHY_OTG_CTRL;
          prog_data_ff <= otg_val;
          req_tgl_ff <= ~req_tgl_ff;
          st_ff <= S_OTG_WAIT;
        end
        S_OTG_WAIT: begin
          if (ack_evt) begin
            st_ff <= EXT_MON ? S_IFC : S_IDLE;
            done_ff <= !EXT_MON;
          end
        end
        S_IFC: begin
          prog_addr_ff <= PHY_IFC_CTRL;
          prog_data_ff <= 8'(EXT_INV) << IFC_IND_INV_BIT;
          req_tgl_ff <= ~req_tgl_ff;
          st_ff <= S_IFC_WAIT;
        end
        S_IFC_WAIT: begin
          if (ack_evt) begin
            done_ff <= 1'b1;
            st_ff <= S_IDLE;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  assign prog_if.req_tgl = req_tgl_ff;
  assign prog_if.addr = prog_addr_ff;
  assign prog_if.data = prog_data_ff;

  ulpi_reg_writer u_writer (
    .link_clk_i(phy_link_clock_i),
    .sys_rst_i(sys_rst_i),
    .prog(prog_if.link),
    .ulpi_dir_i(ulpi_dir_i),
    .ulpi_nxt_i(ulpi_nxt_i),
    .ulpi_data_o(ulpi_data_o),
    .ulpi_data_oe_o(ulpi_data_oe_o),
    .ulpi_stp_o(ulpi_stp_o)
  );
endmodule

// ### usb_cfg_monitor.sv
// Port checks of the host configuration core.
// Assumes a 32-bit register port; bound into each core.
`timescale 1ns/1ns
module usb_cfg_monitor
  import usb_cfg_pkg::*;
#(
  parameter int unsigned full_speed_support_enable = 1,
  parameter int unsigned bus_master_count = 1,
  parameter int unsigned master_id_width = 1,
  parameter int unsigned slave_data_width = 32,
  parameter int unsigned master_data_width = 32,
  parameter logic [31:0] register_window_base = 32'h0000_0000,
  parameter int unsigned system_clock_period_ps = 10000
)
(
  // Clocks and reset
  input logic clk_i,
  input logic sys_rst_i,
  input logic phy_link_clock_i,
  // Register port
  input logic [31:0] reg_addr_i,
  input logic reg_we_i,
  input logic reg_re_i,
  input logic [master_id_width-1:0] requesting_master_identifier_i,
  input logic [slave_data_width-1:0] reg_rdata_o,
  input logic [bus_master_count-1:0] slave_busy_reply_bus_o,
  input logic [bus_master_count-1:0] slave_error_reply_bus_o,
  // DMA and status
  input logic m_req_o,
  input logic [31:0] m_addr_o,
  input logic [master_data_width/8-1:0] m_be_o,
  input logic m_addr_ack_i,
  input logic split_transfer_enable_o,
  input logic phy_reset_o,
  // PHY link
  input logic [7:0] ulpi_data_o,
  input logic ulpi_data_oe_o,
  input logic ulpi_stp_o
);
  localparam int SETTLE =
    (PHY_SETTLE_NS * PS_PER_NS + system_clock_period_ps - 1) / system_clock_period_ps;
  logic in_win;
  logic [15:0] hold_ff;
  assign in_win = reg_addr_i >= register_window_base &&
                  reg_addr_i <= register_window_base + 32'h0000_01FF;
  // PHY reset cycles before release
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_ff <= 16'h0000;
    end else if (phy_reset_o) begin
      hold_ff <= hold_ff + 16'h0001;
    end
  end
  a_rdata_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(reg_re_i) |-> reg_rdata_o == '0) else $error("stray read data");
  a_busy_owner: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_we_i || reg_re_i) && in_win |=> slave_busy_reply_bus_o ==
    (bus_master_count'(1) << $past(requesting_master_identifier_i)))
    else $error("busy on wrong master");
  a_busy_outside: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (reg_we_i || reg_re_i) && !in_win |=> slave_busy_reply_bus_o == '0)
    else $error("busy outside window");
  a_err_beside_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    slave_error_reply_bus_o != '0 |-> slave_error_reply_bus_o == slave_busy_reply_bus_o)
    else $error("error without busy");
  a_split_setting: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> split_transfer_enable_o == (full_speed_support_enable != 0))
    else $error("split enable wrong");
  a_phy_settle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(phy_reset_o) |-> hold_ff >= SETTLE - 1 && hold_ff <= SETTLE + 1)
    else $error("PHY reset release count");
  a_phy_hold_max: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    phy_reset_o |-> hold_ff <= SETTLE + 1) else $error("PHY reset held too long");
  a_dma_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    m_req_o && !m_addr_ack_i |=> m_req_o && $stable(m_addr_o))
    else $error("DMA request unstable");
  a_dma_lanes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    m_req_o |-> m_be_o == (master_data_width/8)'(4'hF)) else $error("DMA byte lanes wrong");
  a_stp_single: assert property (@(posedge phy_link_clock_i) disable iff (sys_rst_i)
    ulpi_stp_o |=> !ulpi_stp_o) else $error("stop too long");
  a_cmd_first: assert property (@(posedge phy_link_clock_i) disable iff (sys_rst_i)
    $rose(ulpi_data_oe_o) |-> ulpi_data_o[7:6] == 2'b10) else $error("frame not a write cmd");
endmodule

bind usb_host_cfg_core usb_cfg_monitor #(
  .full_speed_support_enable(full_speed_support_enable),
  .bus_master_count(bus_master_count), .master_id_width(master_id_width),
  .slave_data_width(slave_data_width), .master_data_width(master_data_width),
  .register_window_base(register_window_base), .system_clock_period_ps(system_clock_period_ps)
) mon (.clk_i, .sys_rst_i, .phy_link_clock_i, .reg_addr_i, .reg_we_i, .reg_re_i,
  .requesting_master_identifier_i, .reg_rdata_o, .slave_busy_reply_bus_o,
  .slave_error_reply_bus_o, .m_req_o, .m_addr_o, .m_be_o, .m_addr_ack_i,
  .split_transfer_enable_o, .phy_reset_o, .ulpi_data_o, .ulpi_data_oe_o, .ulpi_stp_o);

// ### ulpi_phy_model.sv
// PHY model at the link: logs each register write as address and value.
// Assumes a free-running link clock; stall slows the nxt answer.
`timescale 1ns/1ns
module ulpi_phy_model (
  // Link pins
  input logic link_clk_i,
  input logic [7:0] ulpi_data_i,
  input logic ulpi_oe_i,
  input logic ulpi_stp_i,
  output logic ulpi_dir_o,
  output logic ulpi_nxt_o
);
  logic [13:0] log_q[$];
  logic [5:0] addr_ff;
  logic [7:0] val_ff;
  logic stall = 1'b0;
  int beat = 0;
  initial ulpi_dir_o = 1'b0;
  initial ulpi_nxt_o = 1'b0;
  always @(posedge link_clk_i) begin
    if (ulpi_stp_i) begin
      log_q.push_back({addr_ff, val_ff});
      beat = 0;
    end else if (ulpi_nxt_o && ulpi_oe_i) begin
      if (beat == 0) addr_ff <= ulpi_data_i[5:0];
      else val_ff <= ulpi_data_i;
      beat++;
    end
    // Under stall nxt stands every other cycle
    ulpi_nxt_o <= ulpi_oe_i && !ulpi_stp_i && (!stall || !ulpi_nxt_o);
  end
endmodule

// ### tb.sv
// Bench for the host configuration core and a PHY model.
// Assumes the package defaults except the window, two masters, a 20000 ps clock period and inversion on.
`timescale 1ns/1ns
module tb;
  import usb_cfg_pkg::*;
  localparam logic [31:0] BASE = 32'h4000_0000;
  logic clk_i = 1'b0, link_clk_i = 1'b0, sys_rst_i = 1'b1;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, m_addr, m_wdata, d;
  logic we = 1'b0, re = 1'b0, m_req, m_rnw, aack = 1'b0, wack = 1'b0, rack = 1'b0;
  logic [0:0] mid = 1'b0;
  logic [1:0] busy, err, b, e;
  logic [3:0] m_be;
  logic split, phy_rst, uoe, ustp, udir, unxt;
  logic [7:0] udata;
  int failures = 0, tests_run = 0;
  always #10 clk_i = ~clk_i;
  initial begin
    #3;
    forever #6 link_clk_i = ~link_clk_i;
  end
  usb_host_cfg_core #(.external_vbus_monitor_invert(1), .register_window_base(BASE),
    .register_window_high(BASE + 32'h1FF), .bus_master_count(2),
    .system_clock_period_ps(20000)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_be_i(4'hF),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .requesting_master_identifier_i(mid),
    .reg_rdata_o(rdata), .slave_busy_reply_bus_o(busy), .slave_error_reply_bus_o(err),
    .m_req_o(m_req), .m_rnw_o(m_rnw), .m_addr_o(m_addr), .m_be_o(m_be),
    .m_wr_data_o(m_wdata), .m_rd_data_i(32'h1234_ABCD), .m_addr_ack_i(aack),
    .m_wr_ack_i(wack), .m_rd_ack_i(rack), .split_transfer_enable_o(split),
    .phy_reset_o(phy_rst), .phy_link_clock_i(link_clk_i), .ulpi_dir_i(udir),
    .ulpi_nxt_i(unxt), .ulpi_data_o(udata), .ulpi_data_oe_o(uoe), .ulpi_stp_o(ustp));
  ulpi_phy_model phy (.link_clk_i(link_clk_i), .ulpi_data_i(udata), .ulpi_oe_i(uoe),
    .ulpi_stp_i(ustp), .ulpi_dir_o(udir), .ulpi_nxt_o(unxt));
  // Memory side acks each request's address after one cycle and its data one cycle later
  always @(posedge clk_i) begin
    aack <= m_req && !aack;
    wack <= aack && !m_rnw;
    rack <= aack && m_rnw;
  end
  task chk_word(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task chk_phy(input int i, input logic [13:0] x);
    logic [13:0] g;
    g = phy.log_q.size() > i ? phy.log_q[i] : 'x;
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] phy write %0d expected %h seen %h", i, x, g);
    end
  endtask
  task wr(input logic [31:0] a, v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic m);
    @(posedge clk_i);
    addr <= a;
    mid <= m;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1;
    d = rdata;
    b = busy;
    e = err;
  endtask
  task t_caps;
    rd(BASE + OFF_CAPLEN, 1'b0);
    chk_word("caplen", CAPLEN_VAL, d);
    chk_word("busy m0", 32'h1, 32'(b));
    rd(BASE + OFF_STRUCT, 1'b1);
    chk_word("struct", 32'h11, d);
    chk_word("busy m1", 32'h2, 32'(b));
    chk_word("split", 32'h1, 32'(split));
    $display("t_caps done");
  endtask
  task t_window;
    rd(BASE + 32'h30, 1'b0);
    chk_word("unmapped data", 32'h0, d);
    chk_word("unmapped err", 32'h1, 32'(e));
    rd(BASE + 32'h1FC, 1'b0);
    chk_word("top busy", 32'h1, 32'(b));
    rd(BASE + 32'h200, 1'b0);
    chk_word("above busy", 32'h0, 32'(b));
    rd(BASE - 32'h4, 1'b1);
    chk_word("below busy", 32'h0, 32'(b));
    $display("t_window done");
  endtask
  task t_phy;
    for (int i = 0; i < 400 && d[CFG_DONE_BIT] !== 1'b1; i++) rd(BASE + OFF_CONFIG, 1'b0);
    chk_word("config", 32'h11B, d);
    chk_phy(0, {PHY_OTG_CTRL, 8'h80});
    chk_phy(1, {PHY_IFC_CTRL, 8'h20});
    phy.stall = 1'b1;
    wr(BASE + OFF_PHY_CTRL, 32'h1);
    for (int i = 0; i < 400 && phy.log_q.size() < 4; i++) @(posedge clk_i);
    chk_phy(2, {PHY_OTG_CTRL, 8'hC0});
    chk_phy(3, {PHY_IFC_CTRL, 8'h20});
    $display("t_phy done");
  endtask
  task t_dma;
    wr(BASE + OFF_DMA_ADDR, 32'h1000_0040);
    wr(BASE + OFF_DMA_DATA, 32'hA5A5_5A5A);
    wr(BASE + OFF_DMA_CMD, 32'h1);
    for (int i = 0; i < 20 && m_req !== 1'b1; i++) @(negedge clk_i);
    chk_word("dma addr", 32'h1000_0040, m_addr);
    chk_word("dma wdata", 32'hA5A5_5A5A, m_wdata);
    chk_word("dma rnw w", 32'h0, 32'(m_rnw));
    repeat (6) @(posedge clk_i);
    wr(BASE + OFF_DMA_CMD, 32'h3);
    for (int i = 0; i < 20 && m_req !== 1'b1; i++) @(negedge clk_i);
    chk_word("dma rnw r", 32'h1, 32'(m_rnw));
    repeat (6) @(posedge clk_i);
    rd(BASE + OFF_DMA_RDATA, 1'b0);
    chk_word("dma rdata", 32'h1234_ABCD, d);
    $display("t_dma done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    d = 32'h0;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_caps();
    t_window();
    t_phy();
    t_dma();
    results();
  end
endmodule
